// ===== include/opt_pkg.sv
// shared constants and types for the odt power-down transition block
package opt_pkg;

  // link-side odt mode tracker states
  typedef enum logic [1:0]
  {
    OPT_SYNC  = 2'b00,
    OPT_ENTRY = 2'b01,
    OPT_ASYNC = 2'b10,
    OPT_EXIT  = 2'b11
  } opt_state_t;

  // mode register field: bit position and value selecting dll off
  localparam int MR0_DLL_BIT = 12;
  localparam logic DLL_OFF_PD = 1'b0;

  // latency offsets from write latency
  localparam logic [4:0] ODTL_SUB = 5'h02;
  localparam logic [4:0] TANPD_SUB = 5'h01;
  // rtt flop adds one edge, so the tap sits one short of odtl
  localparam logic [4:0] PIPE_OFS = 5'h01;

  // odt history depth and counter widths
  localparam int PIPE_W = 32;
  localparam int CNT_W = 8;
  localparam logic [4:0] AGE_MAX = 5'h1f;

  // configuration reset values
  localparam logic CFG_DLL_RST = 1'b1;
  localparam logic [3:0] CFG_CWL_RST = 4'h5;
  localparam logic [3:0] CFG_AL_RST = 4'h0;

  // clock periods in ps
  localparam int SYS_CK_PS = 10000;
  localparam int LINK_CK_PS = 160000;

  // asynchronous rtt turn-on and turn-off delay bounds in ps
  localparam int AONPD_MIN_PS = 2000;
  localparam int AONPD_MAX_PS = 8500;
  localparam int AOFPD_MIN_PS = 2000;
  localparam int AOFPD_MAX_PS = 8500;

  // async delay bounds in link cycles: least rounds up, longest down
  localparam int ASYNC_MIN_CK_RAW =
    (AONPD_MIN_PS + LINK_CK_PS - 1) / LINK_CK_PS;
  localparam int ASYNC_MAX_CK_RAW = AONPD_MAX_PS / LINK_CK_PS;
  localparam int ASYNC_MIN_CK = (ASYNC_MIN_CK_RAW < 1) ? 1 : ASYNC_MIN_CK_RAW;
  localparam int ASYNC_MAX_CK = (ASYNC_MAX_CK_RAW < 1) ? 1 : ASYNC_MAX_CK_RAW;

  // refresh and dll-off exit times in link cycles (plain defaults)
  localparam logic [7:0] TRFC_CK_DEF = 8'h08;
  localparam logic [7:0] TXPDLL_CK_DEF = 8'h0a;

endpackage

// ===== rtl/opt_sync.sv
// two-flop synchroniser for quasi-static levels
`timescale 1ns/1ps
module opt_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ===== rtl/opt_top.sv
// odt sync/async transition tracker around dll-off precharge power-down
`timescale 1ns/1ps
module opt_top #(
  parameter logic [7:0] TRFC_CK = opt_pkg::TRFC_CK_DEF,
  parameter logic [7:0] TXPDLL_CK = opt_pkg::TXPDLL_CK_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cfg_dll_pd,
  input wire logic [3:0] cfg_cwl,
  input wire logic [3:0] cfg_al,
  input wire logic ck,
  input wire logic cke,
  input wire logic odt,
  input wire logic ref_cmd,
  output logic rtt_en,
  output logic pd_async,
  output logic trans_win,
  output logic rtt_unsure
);

  // system-side configuration registers
  logic cfg_dll_r;
  logic [3:0] cfg_cwl_r;
  logic [3:0] cfg_al_r;
  logic [8:0] cfg_bus;
  logic [8:0] cfg_l;
  logic [2:0] stat_l;
  logic [2:0] stat_s;
  logic link_rst_n;

  // link-side state
  opt_pkg::opt_state_t st_r;
  opt_pkg::opt_state_t st_nxt;
  logic [opt_pkg::CNT_W-1:0] rfc_cnt_r;
  logic [opt_pkg::CNT_W-1:0] rfc_cnt_nxt;
  logic [opt_pkg::CNT_W-1:0] xp_cnt_r;
  logic [opt_pkg::CNT_W-1:0] xp_cnt_nxt;
  logic [opt_pkg::PIPE_W-1:0] odt_pipe_r;
  logic odt_d_r;
  logic [4:0] age_r;
  logic [4:0] age_nxt;
  logic [5:0] unsure_r;
  logic [5:0] unsure_nxt;
  logic rtt_en_r;
  logic rtt_nxt;

  // decoded link-side terms
  wire cfg_dll_l;
  wire [4:0] wl_l;
  wire [4:0] odtl_l;
  wire [4:0] tanpd_l;
  wire [4:0] pipe_idx;
  wire dll_off_l;
  wire ref_busy;
  wire odt_chg;
  wire early_chg;
  wire win_l;
  wire async_now;
  wire edge_win;
  wire unsure_set;
  wire [5:0] unsure_load;

  // configuration latch in the system domain
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      cfg_dll_r <= opt_pkg::CFG_DLL_RST;
      cfg_cwl_r <= opt_pkg::CFG_CWL_RST;
      cfg_al_r <= opt_pkg::CFG_AL_RST;
    end
    else
    begin
      cfg_dll_r <= cfg_dll_pd;
      cfg_cwl_r <= cfg_cwl;
      cfg_al_r <= cfg_al;
    end
  end

  assign cfg_bus = {cfg_dll_r, cfg_cwl_r, cfg_al_r};

  // reset release carried into the link domain
  opt_sync #(.W(1)) u_lrst
  (
    .clk(ck),
    .rst_n(1'b1),
    .d(reset_n),
    .q(link_rst_n)
  );

  // quasi-static config crosses to the link clock; it carries the
  // latch reset values, so dll stays on while the link is in reset
  opt_sync #(.W(9)) u_cfg
  (
    .clk(ck),
    .rst_n(1'b1),
    .d(cfg_bus),
    .q(cfg_l)
  );

  // link status crosses back to the system clock
  opt_sync #(.W(3)) u_stat
  (
    .clk(clk_sys),
    .rst_n(reset_n),
    .d(stat_l),
    .q(stat_s)
  );

  // latency and window decode
  assign cfg_dll_l = cfg_l[8];
  assign wl_l = {1'b0, cfg_l[7:4]} + {1'b0, cfg_l[3:0]};
  assign odtl_l = wl_l - opt_pkg::ODTL_SUB;
  assign tanpd_l = wl_l - opt_pkg::TANPD_SUB;
  assign pipe_idx = odtl_l - opt_pkg::PIPE_OFS;
  assign dll_off_l = (cfg_dll_l == opt_pkg::DLL_OFF_PD);
  assign ref_busy = (rfc_cnt_r > 8'h01);
  assign odt_chg = (odt != odt_d_r);
  assign early_chg = (age_r < tanpd_l);
  assign win_l = (st_r == opt_pkg::OPT_ENTRY) || (st_r == opt_pkg::OPT_EXIT);
  assign async_now = (st_r == opt_pkg::OPT_ASYNC) ||
                     (st_r == opt_pkg::OPT_EXIT);

  // a cke edge that opens a window looks back over tanpd
  assign edge_win = ((st_r == opt_pkg::OPT_SYNC) &&
                     (st_nxt != opt_pkg::OPT_SYNC)) ||
                    ((st_r == opt_pkg::OPT_ASYNC) &&
                     (st_nxt == opt_pkg::OPT_EXIT));
  assign unsure_set = (win_l && odt_chg) ||
                      (edge_win && early_chg);
  assign unsure_load = {1'b0, wl_l} + 6'(opt_pkg::ASYNC_MAX_CK);
  assign unsure_nxt = unsure_set ? unsure_load :
                      ((unsure_r != 6'h00) ? unsure_r - 6'h01 : 6'h00);

  // refresh in progress: loaded on the command, counts to zero
  assign rfc_cnt_nxt = ref_cmd ? TRFC_CK :
                       ((rfc_cnt_r != 8'h00) ? rfc_cnt_r - 8'h01 : 8'h00);

  // age of the last odt change, saturating
  assign age_nxt = odt_chg ? 5'h00 :
                   ((age_r != opt_pkg::AGE_MAX) ? age_r + 5'h01 : age_r);

  // async takes the pin directly, sync takes the latency tap
  assign rtt_nxt = async_now ? odt : odt_pipe_r[pipe_idx];

  // mode transitions on each cke registration
  always_comb
  begin
    st_nxt = st_r;
    xp_cnt_nxt = (xp_cnt_r != 8'h00) ? xp_cnt_r - 8'h01 : 8'h00;
    unique case (st_r)
      opt_pkg::OPT_SYNC:
      begin
        if (dll_off_l && !cke)
        begin
          // refresh still running holds entry open
          st_nxt = ref_busy ? opt_pkg::OPT_ENTRY :
                   opt_pkg::OPT_ASYNC;
        end
      end
      opt_pkg::OPT_ENTRY:
      begin
        if (cke)
        begin
          // short low pulse: straight into the exit window
          st_nxt = opt_pkg::OPT_EXIT;
          xp_cnt_nxt = TXPDLL_CK;
        end
        else if (!ref_busy)
        begin
          st_nxt = opt_pkg::OPT_ASYNC;
        end
      end
      opt_pkg::OPT_ASYNC:
      begin
        if (cke)
        begin
          st_nxt = opt_pkg::OPT_EXIT;
          xp_cnt_nxt = TXPDLL_CK;
        end
      end
      opt_pkg::OPT_EXIT:
      begin
        if (!cke)
        begin
          // short high pulse: back to power-down
          st_nxt = opt_pkg::OPT_ASYNC;
        end
        else if (xp_cnt_r <= 8'h01)
        begin
          st_nxt = opt_pkg::OPT_SYNC;
        end
      end
    endcase
    if (!dll_off_l)
    begin
      st_nxt = opt_pkg::OPT_SYNC;
    end
  end

  // mode state and counters
  always_ff @(posedge ck)
  begin
    if (!link_rst_n)
    begin
      st_r <= opt_pkg::OPT_SYNC;
      rfc_cnt_r <= 8'h00;
      xp_cnt_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      rfc_cnt_r <= rfc_cnt_nxt;
      xp_cnt_r <= xp_cnt_nxt;
    end
  end

  // odt history, change age and uncertainty hold
  always_ff @(posedge ck)
  begin
    if (!link_rst_n)
    begin
      odt_pipe_r <= '0;
      odt_d_r <= 1'b0;
      age_r <= opt_pkg::AGE_MAX;
      unsure_r <= 6'h00;
    end
    else
    begin
      odt_pipe_r <= {odt_pipe_r[opt_pkg::PIPE_W-2:0], odt};
      odt_d_r <= odt;
      age_r <= age_nxt;
      unsure_r <= unsure_nxt;
    end
  end

  // termination enable
  always_ff @(posedge ck)
  begin
    if (!link_rst_n)
    begin
      rtt_en_r <= 1'b0;
    end
    else
    begin
      rtt_en_r <= rtt_nxt;
    end
  end

  // outputs
  assign stat_l = {async_now, win_l, (unsure_r != 6'h00)};
  assign rtt_en = rtt_en_r;
  assign pd_async = stat_s[2];
  assign trans_win = stat_s[1];
  assign rtt_unsure = stat_s[0];

  // checks on the link clock, quiet while the link is in reset
  default clocking link_cb @(posedge ck);
  endclocking
  default disable iff (!link_rst_n);

  a_dll_on_sync: assert property (
    !dll_off_l |=> st_r == opt_pkg::OPT_SYNC)
    else $error("dll on but mode left synchronous");

  a_entry_close: assert property (
    (st_r == opt_pkg::OPT_SYNC && dll_off_l && !cke && !ref_busy)
    |=> st_r == opt_pkg::OPT_ASYNC)
    else $error("entry did not close at first cke low");

  a_ref_extend: assert property (
    (st_r == opt_pkg::OPT_SYNC && dll_off_l && !cke && ref_busy)
    |=> st_r == opt_pkg::OPT_ENTRY)
    else $error("pending refresh did not extend entry");

  a_entry_trfc: assert property (
    (st_r == opt_pkg::OPT_ENTRY && dll_off_l && !cke &&
     rfc_cnt_r == 8'h01) |=> st_r == opt_pkg::OPT_ASYNC)
    else $error("entry did not close when refresh ended");

  a_exit_close: assert property (
    (st_r == opt_pkg::OPT_EXIT && dll_off_l && cke &&
     xp_cnt_r == 8'h01) |=> st_r == opt_pkg::OPT_SYNC)
    else $error("exit window did not close after txpdll");

  a_exit_open: assert property (
    (st_r == opt_pkg::OPT_ASYNC && dll_off_l && cke)
    |=> (st_r == opt_pkg::OPT_EXIT && xp_cnt_r == TXPDLL_CK))
    else $error("exit window not opened on cke high");

  a_short_low: assert property (
    (st_r == opt_pkg::OPT_ENTRY && dll_off_l && cke)
    |=> st_r == opt_pkg::OPT_EXIT)
    else $error("short cke low did not enter exit window");

  a_short_high: assert property (
    (st_r == opt_pkg::OPT_EXIT && dll_off_l && !cke)
    |=> st_r == opt_pkg::OPT_ASYNC)
    else $error("short cke high did not return to async");

  a_async_direct: assert property (
    ($past(st_r) == opt_pkg::OPT_ASYNC && $past(link_rst_n))
    |-> rtt_en_r == $past(odt))
    else $error("async rtt not following odt directly");

  a_sync_latency: assert property (
    ($past(st_r) == opt_pkg::OPT_SYNC && $past(wl_l) == 5'h05 &&
     $past(wl_l, 4) == 5'h05 && $past(link_rst_n, 4))
    |-> rtt_en_r == $past(odt, 4))
    else $error("sync rtt latency wrong");

  a_unsure_hold: assert property (
    (win_l && odt_chg && wl_l >= 5'h05) |=> (unsure_r != 6'h00) [*4])
    else $error("odt change in window not held uncertain");

  a_unsure_edge: assert property (
    (edge_win && early_chg) |=> unsure_r == $past(unsure_load))
    else $error("late odt change before cke edge not flagged");

  // main scenarios
  c_ref_entry: cover property (
    st_r == opt_pkg::OPT_ENTRY ##1 st_r == opt_pkg::OPT_ASYNC);

  c_short_low: cover property (
    st_r == opt_pkg::OPT_ENTRY ##1 st_r == opt_pkg::OPT_EXIT);

  c_short_high: cover property (
    st_r == opt_pkg::OPT_EXIT ##1 st_r == opt_pkg::OPT_ASYNC);

  c_full_exit: cover property (
    st_r == opt_pkg::OPT_EXIT ##1 st_r == opt_pkg::OPT_SYNC);

endmodule

// ===== bench/opt_ctrl_model.sv
// controller-side model driving cke, odt and refresh on the link
`timescale 1ns/1ps
module opt_ctrl_model (
  input wire logic ck,
  output logic cke,
  output logic odt,
  output logic ref_cmd
);
  // pins start idle: clock enabled, no termination, no refresh
  initial
  begin
    cke = 1'h1;
    odt = 1'h0;
    ref_cmd = 1'h0;
  end

  // pins change after a falling ck edge, then n rising edges pass
  task automatic step(input logic c, input logic o, input logic r,
    input int n);
    @(negedge ck);
    cke = c;
    odt = o;
    ref_cmd = r & c; // refresh only with cke high
    repeat (n)
    begin
      @(negedge ck);
      ref_cmd = 1'h0;
    end
  endtask
endmodule

// ===== bench/opt_top_bench.sv
// self-checking bench for the odt power-down transition block
`timescale 1ns/1ps
module opt_top_bench;
  localparam logic [7:0] TRFC = 8'h06;
  localparam logic [7:0] TXP = 8'h05;
  typedef struct packed
  {
    logic dll;
    logic [3:0] cwl;
    logic [3:0] al;
    logic cke;
    logic [7:0] lat;
  } opt_row_t;
  logic clk_sys = 1'h0;
  logic ck = 1'h0;
  logic reset_n = 1'h0;
  logic cfg_dll_pd = 1'h1;
  logic [3:0] cfg_cwl = 4'h5;
  logic [3:0] cfg_al = 4'h0;
  logic cke, odt, ref_cmd, rtt_en, pd_async, trans_win, rtt_unsure;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int k;
  // dll bit, cwl, al, cke level, edges until rtt turns on
  opt_row_t rows [6] = '{
    '{1'h0, 4'h5, 4'h0, 1'h1, 8'h04},
    '{1'h0, 4'h6, 4'h0, 1'h1, 8'h05},
    '{1'h0, 4'h5, 4'h4, 1'h1, 8'h08},
    '{1'h1, 4'h5, 4'h0, 1'h0, 8'h04},
    '{1'h0, 4'h5, 4'h0, 1'h0, 8'h01},
    '{1'h0, 4'h5, 4'h4, 1'h0, 8'h01}};

  opt_top #(.TRFC_CK(TRFC), .TXPDLL_CK(TXP)) opt_top_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .cfg_dll_pd(cfg_dll_pd),
    .cfg_cwl(cfg_cwl), .cfg_al(cfg_al), .ck(ck), .cke(cke),
    .odt(odt), .ref_cmd(ref_cmd), .rtt_en(rtt_en),
    .pd_async(pd_async), .trans_win(trans_win),
    .rtt_unsure(rtt_unsure));

  opt_ctrl_model opt_ctrl_model_i (.ck(ck), .cke(cke), .odt(odt),
    .ref_cmd(ref_cmd));

  // 100 mhz system clock; link clock offset so edges never align
  always #5 clk_sys = ~clk_sys;
  always #80 ck <= #3 ~ck;

  // hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // status pair compare
  task automatic stat(input logic pa, input logic tw);
    check("pd_async", 8'(pd_async), 8'(pa));
    check("trans_win", 8'(trans_win), 8'(tw));
  endtask

  // hold reset over 20 link cycles, outputs must sit low
  task automatic do_reset();
    @(negedge clk_sys);
    reset_n = 1'h0;
    repeat (20) @(negedge ck);
    stat(1'h0, 1'h0);
    check("rtt_en", 8'(rtt_en), 8'h00);
    check("rtt_unsure", 8'(rtt_unsure), 8'h00);
    @(negedge clk_sys);
    reset_n = 1'h1;
    opt_ctrl_model_i.step(1'h1, 1'h0, 1'h0, 6);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    do_reset();
    // latency of rtt turn-on in sync mode for cwl/al 5/0, 6/0 and 5/4, and in async mode for 5/0 and 5/4
    foreach (rows[i])
    begin
      @(negedge clk_sys);
      cfg_dll_pd = rows[i].dll;
      cfg_cwl = rows[i].cwl;
      cfg_al = rows[i].al;
      opt_ctrl_model_i.step(1'h1, 1'h0, 1'h0, 12);
      opt_ctrl_model_i.step(rows[i].cke, 1'h0, 1'h0, 12);
      stat(~rows[i].dll & ~rows[i].cke, 1'h0);
      opt_ctrl_model_i.step(rows[i].cke, 1'h1, 1'h0, 0);
      k = 0;
      while (rtt_en !== 1'h1 && k < 16)
      begin
        @(negedge ck);
        k++;
      end
      check("rtt_on_lat", 8'(k), rows[i].lat);
      opt_ctrl_model_i.step(1'h1, 1'h0, 1'h0, 20);
    end
    // refresh in progress stretches entry
    opt_ctrl_model_i.step(1'h1, 1'h0, 1'h1, 1);
    opt_ctrl_model_i.step(1'h0, 1'h0, 1'h0, 2);
    stat(1'h0, 1'h1);
    opt_ctrl_model_i.step(1'h0, 1'h0, 1'h0, 4);
    stat(1'h1, 1'h0);
    // exit window lasts the exit time after cke high
    opt_ctrl_model_i.step(1'h1, 1'h0, 1'h0, 2);
    stat(1'h1, 1'h1);
    opt_ctrl_model_i.step(1'h1, 1'h0, 1'h0, 5);
    stat(1'h0, 1'h0);
    // short cke high pulse falls back to async
    opt_ctrl_model_i.step(1'h0, 1'h0, 1'h0, 4);
    opt_ctrl_model_i.step(1'h1, 1'h0, 1'h0, 1);
    opt_ctrl_model_i.step(1'h0, 1'h0, 1'h0, 2);
    stat(1'h1, 1'h0);
    // short cke low pulse during refresh entry goes to exit
    opt_ctrl_model_i.step(1'h1, 1'h0, 1'h0, 12);
    opt_ctrl_model_i.step(1'h1, 1'h0, 1'h1, 1);
    opt_ctrl_model_i.step(1'h0, 1'h0, 1'h0, 1);
    opt_ctrl_model_i.step(1'h1, 1'h0, 1'h0, 1);
    stat(1'h1, 1'h1);
    // odt change long before entry leaves rtt certain
    opt_ctrl_model_i.step(1'h1, 1'h0, 1'h0, 12);
    opt_ctrl_model_i.step(1'h1, 1'h1, 1'h0, 8);
    opt_ctrl_model_i.step(1'h0, 1'h1, 1'h0, 1);
    check("rtt_unsure", 8'(rtt_unsure), 8'h00);
    opt_ctrl_model_i.step(1'h0, 1'h1, 1'h0, 3);
    check("rtt_async", 8'(rtt_en), 8'h01);
    // odt change just before entry makes rtt uncertain
    opt_ctrl_model_i.step(1'h1, 1'h1, 1'h0, 12);
    opt_ctrl_model_i.step(1'h1, 1'h0, 1'h0, 1);
    opt_ctrl_model_i.step(1'h0, 1'h0, 1'h0, 1);
    check("rtt_unsure", 8'(rtt_unsure), 8'h01);
    opt_ctrl_model_i.step(1'h0, 1'h0, 1'h0, 10);
    check("rtt_unsure", 8'(rtt_unsure), 8'h00);
    // odt toggled inside the exit window makes rtt uncertain
    opt_ctrl_model_i.step(1'h1, 1'h0, 1'h0, 1);
    opt_ctrl_model_i.step(1'h1, 1'h1, 1'h0, 1);
    check("rtt_unsure", 8'(rtt_unsure), 8'h01);
    stat(1'h1, 1'h1);
    // second reset in mid-run with odt high
    opt_ctrl_model_i.step(1'h1, 1'h1, 1'h0, 12);
    do_reset();
    // after release rtt comes back through the sync latency
    opt_ctrl_model_i.step(1'h1, 1'h1, 1'h0, 12);
    check("rtt_sync", 8'(rtt_en), 8'h01);
    check("rtt_unsure", 8'(rtt_unsure), 8'h00);
    stat(1'h0, 1'h0);
    close_out();
  end
endmodule
